// ===== design/mfp_pkg.sv
// Package for the multifunction pin mapper: codes, register map, field layout
package mfp_pkg;

  // ==========================================================================
  // Input function codes
  localparam logic [3:0] FN_LOAD = 4'h8;
  localparam logic [3:0] FN_FUNCGEN = 4'h9;
  localparam logic [3:0] FN_MARGIN = 4'ha;
  localparam logic [3:0] FN_RESET = 4'hb;
  localparam logic [3:0] FN_NVMPROG = 4'hc;
  localparam logic [3:0] FN_REGLOCK = 4'hd;

  // ==========================================================================
  // Output status codes
  localparam logic [3:0] ST_NONVOLATILE_BUSY_FLAG = 4'h1;
  localparam logic [3:0] ST_CH_BUSY0 = 4'h4;
  localparam logic [3:0] ST_WIN0 = 4'h8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_CONFIG = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_SWTRIG = 12'h008;

  // Config field positions
  localparam int POS_IFS = 0;
  localparam int POS_CSM = 4;
  localparam int POS_OSS = 8;
  localparam int POS_OEN = 12;
  localparam int POS_IEN = 13;
  localparam int POS_NVRST = 14;

  // Reset values
  localparam logic [14:0] CONFIG_RST = 15'h0000;
  localparam logic GATE_RST = 1'b0;
  // Cycles after reset before the pin chain holds real samples
  localparam logic [2:0] SYNC_FILL = 3'h4;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [3:0] load;
    logic [3:0] func_start;
    logic [3:0] func_stop;
    logic [3:0] margin_high;
    logic [3:0] margin_low;
  } mfp_chan_trig_s;

  typedef struct packed {
    logic device_reset;
    logic nvm_prog_allow;
    logic reg_write_allow;
  } mfp_global_s;

endpackage

// ===== design/mfp_pin_mapper.sv
// Multifunction pin mapper with APB register slave
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps

//
// Contract
// RL1: Code 1000: falling edge loads selected channels; rising does nothing.
// RL2: Code 1001 falling stops, rising starts generator; 1010 falling margin-low, rising high.
// RL3: Code 1011: low pulse resets device; mapping kept in nonvolatile copy across resets.
// RL4: Code 1100 falling allows, rising blocks NVM programming; 1101 falling allows writes.
// RL5: Code 1101 rising blocks register writes except unlock field and two-wire reset field.
// RL6: Output pin shows Nonvolatile_busy_flag, channel busy or window result per status code.
// RL7: Input enable makes pin input, output enable makes output; default no function.
// RL8: After boot sample pin level once and run command; afterwards only edges.
// RL9: Mapped input function disables matching software trigger bit.
// RL10: Pin synchronised through flip-flops before edge or pulse detection.
module mfp_pin_mapper
  import mfp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Persistent configuration copy and write-path qualifiers
  input wire logic [14:0] nv_config,
  input wire logic nv_valid,
  input wire logic wr_is_unlock,
  input wire logic wr_is_twowire_reset,
  // Status sources
  input wire logic nonvolatile_busy_flag,
  input wire logic [3:0] chan_busy,
  input wire logic [3:0] window_result,
  // Pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  // Function outputs
  output mfp_chan_trig_s chan_trig,
  output mfp_global_s global_ctl,
  output logic reg_write_ok
);

  // ==========================================================================
  // Configuration register
  logic [14:0] config_q;
  logic [19:0] swtrig_q;
  logic boot_done;
  logic [3:0] input_function_select;
  logic [3:0] channel_select_mask;
  logic [3:0] output_status_select;
  logic pin_output_enable;
  logic pin_input_enable;

  assign input_function_select = config_q[POS_IFS +: 4];
  assign channel_select_mask = config_q[POS_CSM +: 4];
  assign output_status_select = config_q[POS_OSS +: 4];
  assign pin_output_enable = config_q[POS_OEN];
  assign pin_input_enable = config_q[POS_IEN];

  // ==========================================================================
  // APB decode
  wire apb_wr = psel && penable && pwrite;
  wire sel_cfg = (paddr == OFF_CONFIG);
  wire sel_sts = (paddr == OFF_STATUS);
  wire sel_swt = (paddr == OFF_SWTRIG);
  wire addr_ok = sel_cfg || sel_sts || sel_swt;
  logic lock_active;
  // Lock blocks config writes unless the write targets an exempt field
  wire wr_allowed = !lock_active || wr_is_unlock || wr_is_twowire_reset; // [RL5]
  wire cfg_wr = apb_wr && sel_cfg && wr_allowed;
  wire swt_wr = apb_wr && sel_swt && wr_allowed;

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!addr_ok || (pwrite && !wr_allowed && !sel_sts));
  assign reg_write_ok = wr_allowed;

  wire [31:0] status_word = {22'h000000, lock_active, window_result, chan_busy, nonvolatile_busy_flag};
  wire [31:0] rd_mux = sel_cfg ? {17'h00000, config_q} :
                       sel_sts ? status_word : 32'h00000000;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // Config reload from persistent copy after reset, so a reset mapping survives
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      config_q <= CONFIG_RST; // [RL7]
    end else if (clk_en) begin
      if (!boot_done && nv_valid) begin
        config_q <= nv_config; // [RL3]
      end else if (cfg_wr) begin
        config_q <= pwdata[14:0];
      end
    end
  end

  // ==========================================================================
  // Pin synchroniser
  logic sync1, sync2, sync3, pin_level;
  logic [2:0] fill;
  // Edges count only once the chain holds real samples: no false edge after reset
  wire primed = (fill == SYNC_FILL);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      pin_level <= 1'b1;
      fill <= 3'h0;
    end else if (clk_en) begin
      sync1 <= pin_i; // [RL10]
      sync2 <= sync1;
      sync3 <= sync2;
      if (!primed) fill <= fill + 3'h1;
      if (!primed || sync2 == sync3) begin
        pin_level <= sync3;
      end
    end
  end

  wire stable = primed && (sync2 == sync3);
  wire rise = stable && sync3 && !pin_level;
  wire fall = stable && !sync3 && pin_level;

  // ==========================================================================
  // Boot sample: one level-based command after configuration settles
  logic boot_fire, boot_pend;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      boot_done <= 1'b0;
      boot_pend <= 1'b0;
      boot_fire <= 1'b0;
    end else if (clk_en) begin
      boot_fire <= 1'b0;
      if (!boot_done && nv_valid) begin
        boot_done <= 1'b1;
        boot_pend <= 1'b1;
      end else if (boot_pend && primed) begin
        // Wait for a real pin sample, not the chain's reset value
        boot_pend <= 1'b0;
        boot_fire <= 1'b1; // [RL8]
      end
    end
  end

  wire input_mode = pin_input_enable && !pin_output_enable; // [RL7]
  wire ev_fall = input_mode && (fall || (boot_fire && !pin_level)); // [RL8]
  wire ev_rise = input_mode && (rise || (boot_fire && pin_level));

  wire is_load = (input_function_select == FN_LOAD);
  wire is_fgen = (input_function_select == FN_FUNCGEN);
  wire is_marg = (input_function_select == FN_MARGIN);
  wire is_rst = (input_function_select == FN_RESET);
  wire is_nvm = (input_function_select == FN_NVMPROG);
  wire is_lock = (input_function_select == FN_REGLOCK);

  // ==========================================================================
  // Trigger generation: pin events or software triggers when not pin-mapped
  logic [19:0] next_trig;
  logic [19:0] swtrig_eff;
  logic [3:0] m;
  always_comb begin
    m = channel_select_mask;
    swtrig_eff = swtrig_q;
    if (input_mode && is_load) swtrig_eff[19:16] = 4'h0; // [RL9]
    if (input_mode && is_fgen) swtrig_eff[15:8] = 8'h00; // [RL9]
    if (input_mode && is_marg) swtrig_eff[7:0] = 8'h00; // [RL9]
    next_trig = swtrig_eff;
    if (ev_fall && is_load) next_trig[19:16] = m; // [RL1]
    if (ev_rise && is_fgen) next_trig[15:12] = m; // [RL2]
    if (ev_fall && is_fgen) next_trig[11:8] = m; // [RL2]
    if (ev_rise && is_marg) next_trig[7:4] = m; // [RL2]
    if (ev_fall && is_marg) next_trig[3:0] = m; // [RL2]
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      swtrig_q <= 20'h00000;
      chan_trig <= '0;
    end else if (clk_en) begin
      swtrig_q <= swt_wr ? pwdata[19:0] : 20'h00000;
      chan_trig <= next_trig;
    end
  end

  // ==========================================================================
  // Global controls
  logic nvm_allow, dev_reset;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      nvm_allow <= GATE_RST;
      lock_active <= GATE_RST;
      dev_reset <= 1'b0;
    end else if (clk_en) begin
      // Reset held for the low pulse; released by the rising edge
      if (input_mode && is_rst && ev_fall) dev_reset <= 1'b1; // [RL3]
      else if (rise || !(input_mode && is_rst)) dev_reset <= 1'b0;
      if (input_mode && is_nvm && ev_fall) nvm_allow <= 1'b1; // [RL4]
      else if (input_mode && is_nvm && ev_rise) nvm_allow <= 1'b0; // [RL4]
      if (input_mode && is_lock && ev_fall) lock_active <= 1'b0; // [RL4]
      else if (input_mode && is_lock && ev_rise) lock_active <= 1'b1; // [RL5]
    end
  end

  assign global_ctl = '{device_reset: dev_reset, nvm_prog_allow: nvm_allow,
                        reg_write_allow: wr_allowed};

  // ==========================================================================
  // Status output
  logic next_pin_o;
  wire [3:0] ch_idx = output_status_select - ST_CH_BUSY0;
  wire [3:0] wn_idx = output_status_select - ST_WIN0;
  always_comb begin
    next_pin_o = 1'b0;
    if (output_status_select == ST_NONVOLATILE_BUSY_FLAG) next_pin_o = nonvolatile_busy_flag; // [RL6]
    else if (output_status_select[3:2] == 2'b01) next_pin_o = chan_busy[ch_idx[1:0]]; // [RL6]
    else if (output_status_select[3:2] == 2'b10) next_pin_o = window_result[wn_idx[1:0]];
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (clk_en) begin
      pin_o <= next_pin_o;
      pin_oe <= pin_output_enable; // [RL7]
    end
  end

endmodule // mfp_pin_mapper

// ===== test/mfp_pin_mapper_assertions.sv
// Port-level checker for the pin mapper
`timescale 1ns/100ps
module mfp_pin_mapper_assertions
  import mfp_pkg::*;
(
  // Clock, bus and pin
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic wr_is_unlock,
  input wire logic wr_is_twowire_reset,
  input wire logic pin_i,
  // Results
  input wire logic pslverr,
  input wire logic reg_write_ok,
  input wire mfp_chan_trig_s chan_trig,
  input wire mfp_global_s global_ctl
);
  logic pin_q;
  logic [3:0] fa;
  logic [3:0] ra;
  // Software trigger pulses reach chan_trig two samples after their access
  logic [1:0] swt_q;
  // Cycles since each pin edge; zero at reset so a boot command passes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b1;
      fa <= 4'h0;
      ra <= 4'h0;
      swt_q <= 2'h0;
    end else begin
      pin_q <= pin_i;
      swt_q <= {swt_q[0], psel && penable && pwrite && paddr == OFF_SWTRIG};
      fa <= (pin_q && !pin_i) ? 4'h0 : fa + {3'h0, fa != 4'hf};
      ra <= (!pin_q && pin_i) ? 4'h0 : ra + {3'h0, ra != 4'hf};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_load; |chan_trig.load && !swt_q[1] |-> fa < 4'h8; endproperty
  a_load: assert property (p_load) else $error("load without fall");
  property p_stop; |chan_trig.func_stop && !swt_q[1] |-> fa < 4'h8; endproperty
  a_stop: assert property (p_stop) else $error("stop without fall");
  property p_start; |chan_trig.func_start && !swt_q[1] |-> ra < 4'h8; endproperty
  a_start: assert property (p_start) else $error("start without rise");
  property p_mlo; |chan_trig.margin_low && !swt_q[1] |-> fa < 4'h8; endproperty
  a_mlo: assert property (p_mlo) else $error("margin low without fall");
  property p_mhi; |chan_trig.margin_high && !swt_q[1] |-> ra < 4'h8; endproperty
  a_mhi: assert property (p_mhi) else $error("margin high without rise");
  property p_nvm; $rose(global_ctl.nvm_prog_allow) |-> fa < 4'h8; endproperty
  a_nvm: assert property (p_nvm) else $error("program allow without fall");
  property p_rst; $rose(global_ctl.device_reset) |-> fa < 4'h8; endproperty
  a_rst: assert property (p_rst) else $error("device reset without low");
  property p_blk;
    $fell(reg_write_ok) && $stable(wr_is_unlock) && $stable(wr_is_twowire_reset)
      |-> ra < 4'h8;
  endproperty
  a_blk: assert property (p_blk) else $error("lock without rise");
  property p_ref;
    psel && penable && pwrite && !reg_write_ok && !wr_is_unlock && !wr_is_twowire_reset
      && paddr == OFF_CONFIG |-> pslverr;
  endproperty
  a_ref: assert property (p_ref) else $error("locked write accepted");
endmodule // mfp_pin_mapper_assertions

// ===== test/mfp_pin_ctrl.sv
// External controller model driving the mapper pin
`timescale 1ns/100ps
module mfp_pin_ctrl (
  // Requested level and pin
  input wire logic level,
  output logic pin
);
  // Skewed off the core clock: the controller is unrelated to it
  initial pin = 1'b1;
  always @(level) pin <= #7 level;
endmodule // mfp_pin_ctrl

// ===== test/mfp_pin_mapper_tb.sv
// Self-checking bench for the pin mapper
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module mfp_pin_mapper_tb;
  import mfp_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wr_is_unlock = 1'b0, nonvolatile_busy_flag = 1'b0, level = 1'b1, pready, pslverr, se;
  logic pin, pin_o, pin_oe, reg_write_ok;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] chan_busy = 4'h0, window_result = 4'h0, m;
  logic [7:0] lf = 8'h36;
  logic [14:0] nv_config = 15'h0000;
  logic nv_valid = 1'b0, wr_is_twowire_reset = 1'b0;
  mfp_chan_trig_s chan_trig, acc;
  mfp_global_s global_ctl;
  int err_count = 0, tests_run = 0, cyc = 0;
  always #12.5 mclk = ~mclk;
  mfp_pin_ctrl pm_u (.level(level), .pin(pin));
  mfp_pin_mapper dut_u (.mclk(mclk), .resetn(resetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nv_config(nv_config), .nv_valid(nv_valid),
    .wr_is_unlock(wr_is_unlock), .wr_is_twowire_reset(wr_is_twowire_reset),
    .nonvolatile_busy_flag(nonvolatile_busy_flag),
    .chan_busy(chan_busy), .window_result(window_result), .pin_i(pin), .pin_o(pin_o),
    .pin_oe(pin_oe), .chan_trig(chan_trig), .global_ctl(global_ctl),
    .reg_write_ok(reg_write_ok));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic mfp_chan_trig_s exp_t(input int c, input logic v, input logic [3:0] k);
    exp_t = '0;
    if (c == 8 && !v) exp_t.load = k;
    if (c == 9 && v) exp_t.func_start = k;
    if (c == 9 && !v) exp_t.func_stop = k;
    if (c == 10 && v) exp_t.margin_high = k;
    if (c == 10 && !v) exp_t.margin_low = k;
  endfunction
  function automatic logic exp_o(input logic [3:0] c);
    return c == 4'h1 ? nonvolatile_busy_flag : (c < 4'h8 ? chan_busy[c[1:0]] : window_result[c[1:0]]);
  endfunction
  function automatic logic gbit(input int c);
    return c == 11 ? global_ctl.device_reset :
      (c == 12 ? global_ctl.nvm_prog_allow : global_ctl.reg_write_allow);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Collects every trigger pulse seen while the pin settles
  task automatic pset(input logic v);
    level <= v;
    acc = '0;
    repeat (10) begin
      @(posedge mclk);
      acc = acc | chan_trig;
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    // ==========================================================
    // Output status selection
    for (int c = 0; c < 16; c++) begin
      lf = nx(lf);
      nonvolatile_busy_flag <= lf[0];
      chan_busy <= lf[4:1];
      window_result <= lf[7:4];
      apb(1'b1, OFF_CONFIG, {19'h0, 1'b1, 4'(c), 8'h00});
      repeat (3) @(posedge mclk);
      if (c == 1 || (c > 3 && c < 12)) `CHK(pin_o, exp_o(4'(c)))
      `CHK(pin_oe, 1'b1)
    end
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK(rd, ({22'h0, 1'b0, window_result, chan_busy, nonvolatile_busy_flag}))
    // ==========================================================
    // Channel functions on pin edges, random channel masks
    for (int c = 8; c < 11; c++) begin
      lf = nx(lf);
      m = lf[3:0];
      apb(1'b1, OFF_CONFIG, {18'h0, 1'b1, 5'h0, m, 4'(c)});
      pset(1'b0);
      `CHK(acc, exp_t(c, 1'b0, m))
      pset(1'b1);
      `CHK(acc, exp_t(c, 1'b1, m))
      `CHK(pin_oe, 1'b0)
    end
    // Margin mapped: load software bits act, margin ones are masked
    apb(1'b1, OFF_SWTRIG, 32'h000f_00ff);
    pset(1'b1);
    `CHK(acc.load, 4'hf)
    `CHK(acc.margin_high | acc.margin_low, 4'h0)
    // Mapped load makes its software bits inert
    apb(1'b1, OFF_CONFIG, {18'h0, 1'b1, 9'h0, FN_LOAD});
    apb(1'b1, OFF_SWTRIG, 32'h000f_0000);
    pset(1'b1);
    `CHK(acc.load, 4'h0)
    // ==========================================================
    // Global functions, write lock last
    for (int c = 11; c < 14; c++) begin
      apb(1'b1, OFF_CONFIG, {18'h0, 1'b1, 9'h0, 4'(c)});
      pset(1'b0);
      `CHK(gbit(c), 1'b1)
      pset(1'b1);
      `CHK(gbit(c), 1'b0)
    end
    apb(1'b1, OFF_CONFIG, 32'h0);
    `CHK(se, 1'b1)
    apb(1'b0, OFF_CONFIG, 32'h0);
    `CHK(rd, ({17'h0, 2'b01, 9'h0, FN_REGLOCK}))
    wr_is_unlock <= 1'b1;
    apb(1'b1, OFF_CONFIG, {18'h0, 1'b1, 9'h0, FN_REGLOCK});
    `CHK(se, 1'b0)
    wr_is_unlock <= 1'b0;
    wr_is_twowire_reset <= 1'b1;
    apb(1'b1, OFF_CONFIG, {18'h0, 1'b1, 9'h0, FN_REGLOCK});
    `CHK(se, 1'b0)
    wr_is_twowire_reset <= 1'b0;
    pset(1'b0);
    apb(1'b1, OFF_CONFIG, 32'h0);
    `CHK(se, 1'b0)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK(se, 1'b1)
    // ==========================================================
    // Mid-run reset: stored generator mapping, pin held low at boot
    lf = nx(lf);
    m = lf[3:0] | 4'h1;
    nv_config <= {2'b11, 5'h0, m, FN_FUNCGEN};
    nv_valid <= 1'b1;
    level <= 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    pset(1'b0);
    `CHK(acc, exp_t(9, 1'b0, m))
    apb(1'b0, OFF_CONFIG, 32'h0);
    `CHK(rd, ({17'h0, nv_config}))
    pset(1'b1);
    `CHK(acc, exp_t(9, 1'b1, m))
    close_out;
  end
endmodule // mfp_pin_mapper_tb
bind mfp_pin_mapper mfp_pin_mapper_assertions chk_u (.mclk(mclk), .resetn(resetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .wr_is_unlock(wr_is_unlock), .wr_is_twowire_reset(wr_is_twowire_reset), .pin_i(pin_i),
  .pslverr(pslverr), .reg_write_ok(reg_write_ok), .chan_trig(chan_trig),
  .global_ctl(global_ctl));
